// ---- hw/clk_ctrl_pkg.sv ----
// Constants, register map and types for the system clock control block.
// Assumes a 32-bit AXI4-Lite master; each 16-bit register sits in one aligned word.
package clk_ctrl_pkg;

   // ----------------------------------------------------------------
   // Bus widths and responses
   // ----------------------------------------------------------------
   localparam int unsigned ADDR_W      = 18;
   localparam int unsigned DATA_W      = 32;
   localparam int unsigned REG_W       = 16;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;
   localparam logic [1:0]  RESP_DECERR = 2'h3;

   // ----------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam logic [15:0] IDX_HS_PRESCALE = 16'h701A;
   localparam logic [15:0] IDX_LS_PRESCALE = 16'h701B;
   localparam logic [15:0] IDX_CLOCK_GATE  = 16'h701C;
   localparam logic [15:0] IDX_LOW_POWER_0 = 16'h701E;
   localparam logic [15:0] IDX_LOW_POWER_1 = 16'h701F;
   localparam logic [15:0] IDX_RATIO       = 16'h7021;
   localparam logic [15:0] IDX_SYS_STATUS  = 16'h7022;
   localparam logic [15:0] IDX_WD_COUNT    = 16'h7023;
   localparam logic [15:0] IDX_WD_KEY      = 16'h7025;
   localparam logic [15:0] IDX_WD_CONTROL  = 16'h7029;
   localparam logic [15:0] IDX_ACCESS_CTRL = 16'h7040;

   localparam int unsigned NUM_SLOTS = 11;
   localparam logic [3:0]  SLOT_HS     = 4'h0;
   localparam logic [3:0]  SLOT_LS     = 4'h1;
   localparam logic [3:0]  SLOT_GATE   = 4'h2;
   localparam logic [3:0]  SLOT_RATIO  = 4'h5;
   localparam logic [3:0]  SLOT_ACCESS = 4'hA;
   localparam logic [3:0]  SLOT_NONE   = 4'hF;
   localparam logic [15:0] SLOT_INDEX [NUM_SLOTS] = '{
      IDX_HS_PRESCALE, IDX_LS_PRESCALE, IDX_CLOCK_GATE, IDX_LOW_POWER_0,
      IDX_LOW_POWER_1, IDX_RATIO, IDX_SYS_STATUS, IDX_WD_COUNT,
      IDX_WD_KEY, IDX_WD_CONTROL, IDX_ACCESS_CTRL};

   // ----------------------------------------------------------------
   // Fields and reset values
   // ----------------------------------------------------------------
   localparam int unsigned RATIO_W      = 4;
   localparam logic [3:0]  RATIO_RESET  = 4'h0;
   localparam logic [3:0]  RATIO_BYPASS = 4'h0;
   localparam logic [3:0]  RATIO_MAX    = 4'hA;
   localparam logic [15:0] GEN_RESET    = 16'h0000;
   localparam int unsigned PRESCALE_W   = 3;
   localparam int unsigned ACC_ALLOW_BIT    = 0;
   localparam int unsigned ACC_SETTLED_BIT  = 1;
   localparam int unsigned ACC_DISABLED_BIT = 2;
   localparam int unsigned ACC_LIMP_BIT     = 3;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int unsigned SETTLE_INPUT_CYCLES = 131072;
   localparam int unsigned SETTLE_W            = 18;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'h1,
      ST_BRESP = 3'h2,
      ST_RRESP = 3'h4
   } bus_state_t;

endpackage : clk_ctrl_pkg

// ---- hw/settle_timer.sv ----
// Down counter that reports when the clock multiplier has had time to lock.
// Assumes start is a one-cycle pulse on aclk; a new start restarts the count.
`timescale 1ns/1ps
module settle_timer
   import clk_ctrl_pkg::*;
#(
   parameter int unsigned CYCLES = SETTLE_INPUT_CYCLES
)
(
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic start,
   output logic      done
);

   logic [SETTLE_W-1:0] count_reg;
   logic [SETTLE_W-1:0] count_next;

   always_comb
   begin
      count_next = count_reg;
      if (start)
         count_next = SETTLE_W'(CYCLES);
      else if (count_reg != '0)
         count_next = count_reg - SETTLE_W'(1);
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         count_reg <= '0;
      else
         count_reg <= count_next;
   end

   // Reset leaves the multiplier bypassed, so it counts as settled
   assign done = (count_reg == '0);

endmodule : settle_timer

// ---- hw/pll_ratio_system_clock_control.sv ----
// System clock control: ratio register, clock control register map, prescaler ticks.
// Assumes an AXI4-Lite master on aclk and an analog multiplier fed by the outputs.
// Contract
// - Low four bits of the ratio register are read/write, reset to zero.
// - Clock is input times n over two; code zero bypasses; codes above ten refused.
// - Upper twelve bits of the ratio register read zero and store nothing.
// - Only the external reset clears the ratio; debugger reset leaves it.
// - Clock, prescaler, low-power and watchdog registers need protected access enabled.
// - Core clock input and system clock output run at one frequency.
// - Two prescalers derive fast and slow peripheral clocks, plus a gate register.
// - Disable pin low during reset removes the multiplier and the halving.
// - With a non-zero ratio and the multiplier not disabled, a limp clock takes over when input clock vanishes.
`timescale 1ns/1ps
module pll_ratio_system_clock_control
   import clk_ctrl_pkg::*;
#(
   parameter int unsigned SETTLE_CYCLES = SETTLE_INPUT_CYCLES
)
(
   input  wire logic                aclk,
   input  wire logic                aresetn,
   input  wire logic                debug_reset,
   input  wire logic                multiplier_disable_pin_n,
   input  wire logic                input_clock_present,
   input  wire logic [ADDR_W-1:0]   awaddr,
   input  wire logic                awvalid,
   output logic                     awready,
   input  wire logic [DATA_W-1:0]   wdata,
   input  wire logic [DATA_W/8-1:0] wstrb,
   input  wire logic                wvalid,
   output logic                     wready,
   output logic [1:0]               bresp,
   output logic                     bvalid,
   input  wire logic                bready,
   input  wire logic [ADDR_W-1:0]   araddr,
   input  wire logic                arvalid,
   output logic                     arready,
   output logic [DATA_W-1:0]        rdata,
   output logic [1:0]               rresp,
   output logic                     rvalid,
   input  wire logic                rready,
   output logic [RATIO_W-1:0]       ratio_code,
   output logic                     multiplier_bypass,
   output logic                     multiplier_disabled,
   output logic                     divide_by_two,
   output logic                     settle_done,
   output logic                     limp_clock_select,
   output logic                     fast_periph_tick,
   output logic                     slow_periph_tick,
   output logic [REG_W-1:0]         periph_clock_gates
);

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   function automatic logic [3:0] slot_of(input logic [ADDR_W-1:0] addr);
      logic [3:0] slot;
      slot = SLOT_NONE;
      if (addr[1:0] == 2'h0)
         for (int i = 0; i < NUM_SLOTS; i++)
            if (addr[ADDR_W-1:2] == SLOT_INDEX[i])
               slot = 4'(i);
      return slot;
   endfunction : slot_of

   function automatic logic [REG_W-1:0] merge(input logic [REG_W-1:0] old_val,
                                              input logic [REG_W-1:0] new_val,
                                              input logic [1:0]       strb);
      return {strb[1] ? new_val[15:8] : old_val[15:8],
              strb[0] ? new_val[7:0]  : old_val[7:0]};
   endfunction : merge

   // ----------------------------------------------------------------
   // Strap and pin synchronisers
   // ----------------------------------------------------------------
   logic strap_meta_reg;
   logic strap_sync_reg;
   logic clk_meta_reg;
   logic clk_sync_reg;
   logic strap_taken_reg;
   logic strap_taken_next;
   logic disabled_reg;
   logic disabled_next;

   always_ff @(posedge aclk)
   begin
      strap_meta_reg <= multiplier_disable_pin_n;
      strap_sync_reg <= strap_meta_reg;
      clk_meta_reg   <= input_clock_present;
      clk_sync_reg   <= clk_meta_reg;
   end

   // Level caught in the first cycle after release still reflects the reset period
   always_comb
   begin
      strap_taken_next = 1'b1;
      disabled_next    = disabled_reg;
      if (!strap_taken_reg)
         disabled_next = !strap_sync_reg;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         strap_taken_reg <= 1'b0;
         disabled_reg    <= 1'b0;
      end
      else
      begin
         strap_taken_reg <= strap_taken_next;
         disabled_reg    <= disabled_next;
      end
   end

   // ----------------------------------------------------------------
   // Register bus
   // ----------------------------------------------------------------
   bus_state_t              state_reg;
   bus_state_t              state_next;
   logic                    aw_have_reg;
   logic                    aw_have_next;
   logic                    w_have_reg;
   logic                    w_have_next;
   logic [ADDR_W-1:0]       aw_addr_reg;
   logic [ADDR_W-1:0]       aw_addr_next;
   logic [REG_W-1:0]        w_data_reg;
   logic [REG_W-1:0]        w_data_next;
   logic [1:0]              w_strb_reg;
   logic [1:0]              w_strb_next;
   logic [1:0]              bresp_reg;
   logic [1:0]              bresp_next;
   logic [1:0]              rresp_reg;
   logic [1:0]              rresp_next;
   logic [DATA_W-1:0]       rdata_reg;
   logic [DATA_W-1:0]       rdata_next;
   logic [REG_W-1:0]        regs_reg  [NUM_SLOTS];
   logic [REG_W-1:0]        regs_next [NUM_SLOTS];
   logic                    ratio_start;
   logic                    wr_fire;
   logic [3:0]              wr_slot;
   logic [3:0]              rd_slot;
   logic [ADDR_W-1:0]       wr_addr;
   logic [REG_W-1:0]        wr_val;
   logic [1:0]              wr_strb;
   logic                    allow;
   logic [REG_W-1:0]        status_word;

   assign allow   = regs_reg[SLOT_ACCESS][ACC_ALLOW_BIT];
   assign awready = (state_reg == ST_IDLE) && !aw_have_reg;
   assign wready  = (state_reg == ST_IDLE) && !w_have_reg;
   // Writes win over reads when both arrive together
   assign arready = (state_reg == ST_IDLE) && !aw_have_reg && !w_have_reg
                    && !awvalid && !wvalid;
   assign wr_addr = aw_have_reg ? aw_addr_reg : awaddr;
   assign wr_val  = w_have_reg ? w_data_reg : wdata[REG_W-1:0];
   assign wr_strb = w_have_reg ? w_strb_reg : wstrb[1:0];
   assign wr_fire = (aw_have_reg || (awvalid && awready))
                    && (w_have_reg || (wvalid && wready));
   assign wr_slot = slot_of(wr_addr);
   assign rd_slot = slot_of(araddr);

   always_comb
   begin
      status_word                   = GEN_RESET;
      status_word[ACC_ALLOW_BIT]    = allow;
      status_word[ACC_SETTLED_BIT]  = settle_done;
      status_word[ACC_DISABLED_BIT] = disabled_reg;
      status_word[ACC_LIMP_BIT]     = limp_clock_select;
   end

   always_comb
   begin
      state_next   = state_reg;
      aw_have_next = aw_have_reg;
      w_have_next  = w_have_reg;
      aw_addr_next = aw_addr_reg;
      w_data_next  = w_data_reg;
      w_strb_next  = w_strb_reg;
      bresp_next   = bresp_reg;
      rresp_next   = rresp_reg;
      rdata_next   = rdata_reg;
      regs_next    = regs_reg;
      ratio_start  = 1'b0;
      // Debugger reset clears every register but the ratio code
      if (debug_reset)
         for (int i = 0; i < NUM_SLOTS; i++)
            if (4'(i) != SLOT_RATIO)
               regs_next[i] = GEN_RESET;
      case (state_reg)
         ST_IDLE:
         begin
            if (awvalid && awready)
            begin
               aw_have_next = 1'b1;
               aw_addr_next = awaddr;
            end
            if (wvalid && wready)
            begin
               w_have_next = 1'b1;
               w_data_next = wdata[REG_W-1:0];
               w_strb_next = wstrb[1:0];
            end
            if (wr_fire)
            begin
               aw_have_next = 1'b0;
               w_have_next  = 1'b0;
               state_next   = ST_BRESP;
               bresp_next   = RESP_OKAY;
               if (wr_slot == SLOT_NONE)
                  bresp_next = RESP_DECERR;
               else if (wr_slot != SLOT_ACCESS && !allow)
                  bresp_next = RESP_SLVERR;
               else if (wr_slot == SLOT_RATIO)
               begin
                  if (wr_strb[0] && wr_val[RATIO_W-1:0] > RATIO_MAX)
                     bresp_next = RESP_SLVERR;
                  else if (wr_strb[0])
                  begin
                     regs_next[SLOT_RATIO] = {12'h000, wr_val[RATIO_W-1:0]};
                     ratio_start           = 1'b1;
                  end
               end
               else if (wr_slot == SLOT_ACCESS)
               begin
                  if (wr_strb[0])
                     regs_next[SLOT_ACCESS] = {15'h0000, wr_val[ACC_ALLOW_BIT]};
               end
               else
                  regs_next[wr_slot] = merge(regs_reg[wr_slot], wr_val, wr_strb);
            end
            else if (arvalid && arready)
            begin
               state_next = ST_RRESP;
               rresp_next = RESP_OKAY;
               rdata_next = '0;
               if (rd_slot == SLOT_NONE)
                  rresp_next = RESP_DECERR;
               else if (rd_slot == SLOT_ACCESS)
                  rdata_next = {16'h0000, status_word};
               else if (!allow)
                  rresp_next = RESP_SLVERR;
               else
                  rdata_next = {16'h0000, regs_reg[rd_slot]};
            end
         end
         ST_BRESP:
            if (bready)
               state_next = ST_IDLE;
         ST_RRESP:
            if (rready)
               state_next = ST_IDLE;
         default:
            state_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state_reg   <= ST_IDLE;
         aw_have_reg <= 1'b0;
         w_have_reg  <= 1'b0;
         aw_addr_reg <= '0;
         w_data_reg  <= '0;
         w_strb_reg  <= 2'h0;
         bresp_reg   <= RESP_OKAY;
         rresp_reg   <= RESP_OKAY;
         rdata_reg   <= '0;
         for (int i = 0; i < NUM_SLOTS; i++)
            regs_reg[i] <= GEN_RESET;
      end
      else
      begin
         state_reg   <= state_next;
         aw_have_reg <= aw_have_next;
         w_have_reg  <= w_have_next;
         aw_addr_reg <= aw_addr_next;
         w_data_reg  <= w_data_next;
         w_strb_reg  <= w_strb_next;
         bresp_reg   <= bresp_next;
         rresp_reg   <= rresp_next;
         rdata_reg   <= rdata_next;
         regs_reg    <= regs_next;
      end
   end

   assign bvalid = (state_reg == ST_BRESP);
   assign bresp  = bresp_reg;
   assign rvalid = (state_reg == ST_RRESP);
   assign rresp  = rresp_reg;
   assign rdata  = rdata_reg;

   // ----------------------------------------------------------------
   // Multiplier controls
   // ----------------------------------------------------------------
   settle_timer #(
      .CYCLES (SETTLE_CYCLES)
   ) u_settle (
      .aclk    (aclk),
      .aresetn (aresetn),
      .start   (ratio_start),
      .done    (settle_done)
   );

   // Core and output clock share one ratio, so one set of controls serves both
   assign ratio_code          = regs_reg[SLOT_RATIO][RATIO_W-1:0];
   assign multiplier_disabled = disabled_reg;
   assign multiplier_bypass   = disabled_reg || (ratio_code == RATIO_BYPASS);
   assign divide_by_two       = !disabled_reg;
   // Limp mode only exists while the multiplier is actually in use
   assign limp_clock_select   = !disabled_reg && (ratio_code != RATIO_BYPASS)
                                && !clk_sync_reg;
   assign periph_clock_gates  = regs_reg[SLOT_GATE];

   // ----------------------------------------------------------------
   // Peripheral clock prescalers: divide by 2n, n zero passes every cycle
   // ----------------------------------------------------------------
   logic [1:0] pre_tick;

   for (genvar p = 0; p < 2; p++)
   begin : g_pre
      logic [3:0] cnt_reg;
      logic [3:0] cnt_next;
      logic [3:0] reload;
      assign reload = {regs_reg[p][PRESCALE_W-1:0], 1'b0} - 4'h1;
      always_comb
      begin
         cnt_next = cnt_reg - 4'h1;
         if (cnt_reg == 4'h0 || cnt_reg > reload)
            cnt_next = reload;
      end
      always_ff @(posedge aclk)
      begin
         if (!aresetn)
            cnt_reg <= 4'h0;
         else
            cnt_reg <= cnt_next;
      end
      assign pre_tick[p] = (regs_reg[p][PRESCALE_W-1:0] == 3'h0) || (cnt_reg == 4'h0);
   end

   assign fast_periph_tick = pre_tick[SLOT_HS[0]];
   assign slow_periph_tick = pre_tick[SLOT_LS[0]];

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence prot_write_s;
      wr_fire && wr_slot != SLOT_ACCESS && wr_slot != SLOT_NONE && !allow;
   endsequence

   sequence ratio_write_s;
      wr_fire && wr_slot == SLOT_RATIO && allow && wr_strb[0]
      && wr_val[RATIO_W-1:0] <= RATIO_MAX;
   endsequence

   ratio_keep_a: assert property (debug_reset && !wr_fire |=> $stable(ratio_code))
      else $error("ratio changed on debugger reset");
   upper_zero_a: assert property (ratio_write_s |=> regs_reg[SLOT_RATIO][15:4] == 12'h000)
      else $error("ratio upper bits hold state");
   code_range_a: assert property (ratio_code <= RATIO_MAX)
      else $error("reserved ratio code stored");
   prot_block_a: assert property (prot_write_s |=> bvalid && bresp == RESP_SLVERR
                                  && $stable(ratio_code))
      else $error("protected write not refused");
   ratio_load_a: assert property (ratio_write_s |=> ratio_code == $past(wr_val[RATIO_W-1:0])
                                  && !settle_done ##1 !settle_done)
      else $error("ratio write lost or settle not restarted");
   bypass_a: assert property (multiplier_bypass == (disabled_reg || ratio_code == 4'h0))
      else $error("bypass indication wrong");
   // The capture edge itself moves disabled_reg, so check only from the edge after it
   strap_a: assert property ($past(strap_taken_reg) |-> $stable(disabled_reg)
                             && divide_by_two == !disabled_reg)
      else $error("strap state moved after capture");
   limp_a: assert property (limp_clock_select |-> ratio_code != 4'h0 && !disabled_reg)
      else $error("limp clock without multiplier");
   fast_tick_a: assert property (regs_reg[SLOT_HS][2:0] == 3'h1 && fast_periph_tick
                                 && $stable(regs_reg[SLOT_HS]) |=> !fast_periph_tick)
      else $error("fast prescaler divide by two broken");

endmodule : pll_ratio_system_clock_control

// ---- testbench/ref_clock_source.sv ----
// Model of the reference clock source and the multiplier disable strap.
// Assumes the bench commands clock loss and strap level; all on aclk.
`timescale 1ns/1ps
module ref_clock_source
(
   input  wire logic aclk,
   input  wire logic clock_lost,
   input  wire logic strap_low,
   output logic      input_clock_present,
   output logic      multiplier_disable_pin_n
);
   initial
   begin
      input_clock_present      = 1'b1;
      multiplier_disable_pin_n = 1'b1;
   end
   // A real detector lags the oscillator, so loss shows one edge late
   always @(posedge aclk)
   begin
      input_clock_present      <= !clock_lost;
      multiplier_disable_pin_n <= !strap_low;
   end
endmodule : ref_clock_source

// ---- testbench/tb.sv ----
// Self-checking bench for the system clock control block.
// Assumes the package constants and an AXI4-Lite slave answering after one cycle.
`timescale 1ns/1ps
module tb
   import clk_ctrl_pkg::*;
;
   localparam logic [17:0] A_RATIO = {IDX_RATIO, 2'h0};
   localparam logic [17:0] A_ACC   = {IDX_ACCESS_CTRL, 2'h0};
   localparam logic [17:0] A_HS    = {IDX_HS_PRESCALE, 2'h0};
   localparam logic [17:0] A_LS    = {IDX_LS_PRESCALE, 2'h0};
   localparam logic [17:0] A_GATE  = {IDX_CLOCK_GATE, 2'h0};
   logic aclk = 0, aresetn = 0, debug_reset = 0, clock_lost = 0, strap_low = 0;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
   logic [DATA_W-1:0] wdata = '0, rdata, r;
   logic [3:0]        wstrb = 4'hF, ratio_code, c, prev;
   logic [1:0]        bresp, rresp;
   logic              awready, wready, bvalid, arready, rvalid, present, strap_n;
   logic              multiplier_bypass, multiplier_disabled, divide_by_two, settle_done;
   logic              limp_clock_select, fast_periph_tick, slow_periph_tick;
   logic [15:0]       periph_clock_gates;
   logic [34:0]       exp_q[$];
   logic [34:0]       e;
   logic [31:0]       seed = 32'hCE3FD6AD;
   int                n_mismatch = 0, tests_run = 0, cyc = 0, cnt, i, k, per;

   always #20 aclk = ~aclk;

   ref_clock_source ref_clock_source_inst (.aclk(aclk), .clock_lost(clock_lost),
      .strap_low(strap_low), .input_clock_present(present),
      .multiplier_disable_pin_n(strap_n));

   // Short settle count keeps the run brief
   pll_ratio_system_clock_control #(.SETTLE_CYCLES(16)) pll_ratio_system_clock_control_inst (
      .aclk(aclk), .aresetn(aresetn), .debug_reset(debug_reset),
      .multiplier_disable_pin_n(strap_n), .input_clock_present(present),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .ratio_code(ratio_code),
      .multiplier_bypass(multiplier_bypass), .multiplier_disabled(multiplier_disabled),
      .divide_by_two(divide_by_two), .settle_done(settle_done),
      .limp_clock_select(limp_clock_select), .fast_periph_tick(fast_periph_tick),
      .slow_periph_tick(slow_periph_tick), .periph_clock_gates(periph_clock_gates));

   // ----------------------------------------------------------------
   // Checking and bus tasks
   // ----------------------------------------------------------------
   task chk(input bit ok, input string m);
      tests_run++;
      if (!ok)
      begin
         n_mismatch++;
         $display("[ERR] %0t %s", $time, m);
      end
   endtask : chk

   task summarize;
      $display("counts: %0d mismatches in %0d checks", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : summarize

   task wr(input logic [17:0] a, input logic [31:0] d, input logic [1:0] er);
      bit ad, wd;
      ad = 0;
      wd = 0;
      exp_q.push_back({1'b0, er, 32'h0});
      awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      while (!(ad && wd))
      begin
         @(posedge aclk);
         if (!ad && awready === 1'b1) begin ad = 1; awvalid <= 1'b0; end
         if (!wd && wready === 1'b1) begin wd = 1; wvalid <= 1'b0; end
      end
      do @(posedge aclk); while (bvalid !== 1'b1);
      bready <= 1'b0;
      // One idle edge keeps a following call from re-raising bready in the same step
      @(posedge aclk);
   endtask : wr

   task rd(input logic [17:0] a, input logic [31:0] d, input logic [1:0] er);
      exp_q.push_back({1'b1, er, d});
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      rready <= 1'b0;
      @(posedge aclk);
   endtask : rd

   task do_reset(input logic low);
      strap_low <= low;
      aresetn   <= 1'b0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
   endtask : do_reset

   always @(posedge aclk)
   begin
      cyc++;
      if (cyc == 20000) begin n_mismatch++; summarize(); end
      if (aresetn && bvalid === 1'b1 && bready === 1'b1)
      begin
         e = exp_q.pop_front();
         chk(e[34] === 1'b0 && bresp === e[33:32], "write response");
      end
      if (aresetn && rvalid === 1'b1 && rready === 1'b1)
      begin
         e = exp_q.pop_front();
         chk(e[34] === 1'b1 && rresp === e[33:32] && rdata === e[31:0], "read response");
      end
   end

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   initial
   begin
      do_reset(1'b0);
      chk(multiplier_disabled === 1'b0 && divide_by_two === 1'b1, "strap high");
      rd(A_RATIO, 32'h0, RESP_SLVERR);
      wr(A_HS, 32'h5, RESP_SLVERR);
      rd(A_ACC, 32'h2, RESP_OKAY);
      wr(A_ACC, 32'h1, RESP_OKAY);
      rd(A_RATIO, 32'h0, RESP_OKAY);
      rd(A_HS, 32'h0, RESP_OKAY);
      rd({16'h701D, 2'h0}, 32'h0, RESP_DECERR);
      $display("test protection done");
      prev = 4'h0;
      for (i = 1; i < 17; i++)
      begin
         c = i[3:0];
         if (c <= RATIO_MAX) prev = c;
         wr(A_RATIO, {28'hFFFFFFF, c}, (c <= RATIO_MAX) ? RESP_OKAY : RESP_SLVERR);
         rd(A_RATIO, {28'h0, prev}, RESP_OKAY);
         chk(ratio_code === prev && multiplier_bypass === (prev == 0), "ratio out");
      end
      $display("test ratio codes done");
      wr(A_RATIO, 32'h3, RESP_OKAY);
      chk(settle_done === 1'b0, "settle start");
      cnt = 0;
      while (settle_done !== 1'b1 && cnt < 100) begin @(posedge aclk); cnt++; end
      chk(cnt >= 12 && cnt <= 17, "settle length");
      clock_lost <= 1'b1;
      repeat (5) @(posedge aclk);
      chk(limp_clock_select === 1'b1, "limp on");
      rd(A_ACC, 32'hB, RESP_OKAY);
      clock_lost <= 1'b0;
      repeat (5) @(posedge aclk);
      chk(limp_clock_select === 1'b0, "limp off");
      $display("test settle and limp done");
      debug_reset <= 1'b1;
      @(posedge aclk);
      debug_reset <= 1'b0;
      @(posedge aclk);
      chk(ratio_code === 4'h3, "debug reset kept ratio");
      rd(A_RATIO, 32'h0, RESP_SLVERR);
      wr(A_ACC, 32'h1, RESP_OKAY);
      rd(A_RATIO, 32'h3, RESP_OKAY);
      $display("test debug reset done");
      for (k = 0; k < 2; k++)
      begin
         r = $random(seed);
         // Fast side at n=1 so the divide-by-two check sees its case
         if (k == 0)
            r[2:0] = 3'h1;
         wr(k ? A_LS : A_HS, r, RESP_OKAY);
         rd(k ? A_LS : A_HS, {16'h0, r[15:0]}, RESP_OKAY);
         per = (r[2:0] == 0) ? 1 : 2 * r[2:0];
         repeat (4) @(posedge aclk);
         cnt = 0;
         repeat (per * 8)
         begin
            @(posedge aclk);
            cnt += ((k ? slow_periph_tick : fast_periph_tick) === 1'b1);
         end
         chk(cnt == 8, "prescaler tick rate");
      end
      wr(A_GATE, r, RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk(periph_clock_gates === r[15:0], "gate control");
      $display("test prescalers done");
      do_reset(1'b1);
      chk(multiplier_disabled === 1'b1 && divide_by_two === 1'b0, "strap low");
      chk(multiplier_bypass === 1'b1 && ratio_code === 4'h0, "pin reset ratio");
      rd(A_ACC, 32'h6, RESP_OKAY);
      $display("test strap reset done");
      summarize();
   end
endmodule : tb
